// File: hw/pfps_seq.sv
// Pitch-feed and pressing sequencer with position table
// Function
// - Incremental entry: new target is stop position plus pitch.
// - Targets are absolute from home so pitches never accumulate error.
// - Pitch past software stroke limit stops at limit with in-position.
// - Pitch after pressing bases on pressing entry position.
// - Pitch started mid-positioning adds to running target each start.
// - Paused pitch starts add up; alarm clear while paused discards.
// - Start sets motion-active, drops in-position; idle clears motion.
// - In-position asserts within positioning width, even while moving.
// - Pitch start during pressing aborts pressing and feeds at once.
// - Nonzero pressing percent selects pressing; width is travel.
// - Approach at rated torque, then press at limited current.
// - Pressing stop sets in-position; full-travel miss leaves it low.
// - Completed position number reads zero while moving.
// - Accumulate time at or over limit; 255 ms sets in-position.
// - A newly started entry always pre-empts the earlier one.
`include "pfps_defines.svh"
module pfps_seq
    import pfps_pkg::*;
#(
    parameter int DEPTH    = 512,
    parameter int TICK_CYC = `PFPS_TICK_CYC
) (
    input  wire logic                          sys_clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic [`PFPS_ADDR_W-1:0]       reg_addr_i,
    input  wire logic [`PFPS_DATA_W-1:0]       reg_wdata_i,
    input  wire logic                          reg_we_i,
    input  wire logic                          reg_re_i,
    output logic      [`PFPS_DATA_W-1:0]       reg_rdata_o,
    input  wire logic                          position_start_strobe_i,
    input  wire logic [`PFPS_SEL_W-1:0]        position_select_bits_i,
    input  wire logic                          alarm_clear_input_i,
    input  wire logic                          pause_i,
    input  wire logic signed [`PFPS_POS_W-1:0] act_pos_i,
    input  wire logic [`PFPS_PCT_W-1:0]        motor_cur_pct_i,
    output logic signed [`PFPS_POS_W-1:0]      target_pos_o,
    output logic      [`PFPS_PCT_W-1:0]        cur_limit_o,
    output logic                               servo_hold_o,
    output logic                               in_position_flag_o,
    output logic                               motion_active_o,
    output logic      [`PFPS_SEL_W-1:0]        completed_position_bits_o
);
    localparam int CW = $clog2(TICK_CYC);
    localparam int IW = $clog2(DEPTH);
    localparam int PW = `PFPS_POS_W;

    // ----------------------------------------------------------------
    // Pin synchronisation and start edge
    // ----------------------------------------------------------------
    pfps_pio_t pio;
    logic      start_prev_q;
    pfps_pin_sync #(
        .W ($bits(pfps_pio_t))
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     ({pause_i, alarm_clear_input_i,
                     position_start_strobe_i, position_select_bits_i}),
        .q_o       (pio)
    );
    wire start_rise = pio.start && !start_prev_q;
    wire discard    = pio.pause && pio.clear;

    // ----------------------------------------------------------------
    // Millisecond tick
    // ----------------------------------------------------------------
    logic [CW-1:0] tick_cnt_q;
    logic          tick_q;
    wire           tick_wrap = (tick_cnt_q == CW'(TICK_CYC - 1));

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 1'b1;
            tick_q     <= tick_wrap;
        end
    end

    // ----------------------------------------------------------------
    // Register file and position table
    // ----------------------------------------------------------------
    logic signed [PW-1:0]   pos_mem [DEPTH];
    logic signed [PW-1:0]   wid_mem [DEPTH];
    logic [`PFPS_PCT_W-1:0] pct_mem [DEPTH];
    logic                   inc_mem [DEPTH];
    logic signed [PW-1:0]   softlim_q;
    logic [IW-1:0]          tab_idx_q;
    logic signed [PW-1:0]   tab_pos_q;
    logic signed [PW-1:0]   tab_wid_q;
    wire wr_softlim = reg_we_i && reg_addr_i == `PFPS_REG_SOFTLIM;
    wire wr_idx     = reg_we_i && reg_addr_i == `PFPS_REG_TAB_IDX;
    wire wr_pos     = reg_we_i && reg_addr_i == `PFPS_REG_TAB_POS;
    wire wr_wid     = reg_we_i && reg_addr_i == `PFPS_REG_TAB_WID;
    wire wr_cfg     = reg_we_i && reg_addr_i == `PFPS_REG_TAB_CFG;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            softlim_q <= `PFPS_SOFTLIM_RST;
            tab_idx_q <= '0;
            tab_pos_q <= '0;
            tab_wid_q <= '0;
        end else begin
            if (wr_softlim) softlim_q <= reg_wdata_i;
            if (wr_idx)     tab_idx_q <= reg_wdata_i[IW-1:0];
            if (wr_pos)     tab_pos_q <= reg_wdata_i;
            if (wr_wid)     tab_wid_q <= reg_wdata_i;
        end
    end

    // Writing the config word commits the staged entry
    always_ff @(posedge sys_clk_i) begin
        if (wr_cfg) begin
            pos_mem[tab_idx_q] <= tab_pos_q;
            wid_mem[tab_idx_q] <= tab_wid_q;
            pct_mem[tab_idx_q] <= reg_wdata_i[`PFPS_PCT_W-1:0];
            inc_mem[tab_idx_q] <= reg_wdata_i[`PFPS_CFG_INC_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Selected entry and target arithmetic
    // ----------------------------------------------------------------
    pfps_entry_t         ent;
    wire [IW-1:0]        ent_idx = IW'(pio.sel);
    assign ent.inc = inc_mem[ent_idx];
    assign ent.pct = pct_mem[ent_idx];
    assign ent.pos = pos_mem[ent_idx];
    assign ent.wid = wid_mem[ent_idx];
    pfps_state_t          st_q;
    logic signed [PW-1:0] tgt_q;
    logic signed [PW-1:0] press_base_q;
    logic signed [PW-1:0] press_end_q;
    logic signed [PW-1:0] wid_q;
    logic [`PFPS_PCT_W-1:0] pct_q;
    logic                 press_in_position_flag_q;
    logic                 from_press_q;
    logic                 in_position_flag_q;
    logic                 move_q;
    logic                 miss_q;
    logic [`PFPS_SEL_W-1:0] cur_sel_q;

    // Pressing and just-pressed moves re-base on the programmed point;
    // otherwise the running target, which also holds any paused backlog
    wire in_press = (st_q == PFPS_PRESS);
    wire signed [PW-1:0] pitch_base =
        (in_press || from_press_q) ? press_base_q :
        tgt_q;
    // One extra bit keeps overflow visible to the clamp
    wire signed [PW:0] inc_raw = {pitch_base[PW-1], pitch_base}
                               + {ent.pos[PW-1], ent.pos};
    // Signed compare, so a negative sum clamps low, not high
    wire over_lim  = inc_raw > $signed({1'b0, softlim_q});
    wire under_lim = inc_raw < 0;
    wire signed [PW-1:0] inc_tgt =
        over_lim  ? softlim_q :
        under_lim ? '0 :
        inc_raw[PW-1:0];
    wire signed [PW-1:0] new_tgt = ent.inc ? inc_tgt : ent.pos;
    wire                 new_press = (ent.pct != '0);
    wire signed [PW-1:0] new_end = new_tgt + ent.wid;

    // ----------------------------------------------------------------
    // Position judgement
    // ----------------------------------------------------------------
    wire signed [PW:0] err =
        {act_pos_i[PW-1], act_pos_i} - {tgt_q[PW-1], tgt_q};
    wire signed [PW:0] err_mag = err[PW] ? -err : err;
    wire signed [PW:0] wid_mag = wid_q[PW-1] ? -{wid_q[PW-1], wid_q}
                                             : {1'b0, wid_q};
    wire at_tgt   = (err == '0);
    wire in_width = (err_mag <= wid_mag);

    // ----------------------------------------------------------------
    // Pressing accumulator
    // ----------------------------------------------------------------
    logic                   acc_clr_q;
    logic                   acc_done;
    logic [`PFPS_ACC_W-1:0] acc_val;
    wire cur_over = in_press && (motor_cur_pct_i >= pct_q);

    pfps_press_acc #(
        .LIMIT (`PFPS_PRESS_TICKS)
    ) u_acc (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .clr_i     (acc_clr_q),
        .tick_i    (tick_q && in_press),
        .over_i    (cur_over),
        .done_o    (acc_done),
        .acc_o     (acc_val)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    wire in_position_flag_d = !start_rise && !discard
               && (in_position_flag_q || (st_q == PFPS_POSN && !press_in_position_flag_q && in_width)
                   || (in_press && acc_done));
    wire move_d = start_rise
               || (move_q && !discard
                   && !(st_q == PFPS_POSN && !press_in_position_flag_q && at_tgt)
                   && !(in_press && (acc_done || at_tgt)));

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q         <= PFPS_IDLE;
            tgt_q        <= '0;
            press_base_q <= '0;
            press_end_q  <= '0;
            wid_q        <= '0;
            pct_q        <= `PFPS_RATED_PCT;
            press_in_position_flag_q <= 1'b0;
            from_press_q <= 1'b0;
            miss_q       <= 1'b0;
            acc_clr_q    <= 1'b1;
            cur_sel_q    <= '0;
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= pio.start;
            acc_clr_q    <= 1'b0;
            if (start_rise) begin
                // Latest start always replaces what runs
                st_q         <= PFPS_POSN;
                tgt_q        <= new_tgt;
                press_in_position_flag_q <= new_press;
                press_base_q <= new_press ? new_tgt : press_base_q;
                press_end_q  <= new_end;
                wid_q        <= ent.wid;
                pct_q        <= new_press ? ent.pct : `PFPS_RATED_PCT;
                from_press_q <= 1'b0;
                miss_q       <= 1'b0;
                acc_clr_q    <= 1'b1;
                cur_sel_q    <= pio.sel;
            end else if (discard) begin
                // Remaining distance dropped while paused
                st_q         <= PFPS_IDLE;
                tgt_q        <= act_pos_i;
                press_in_position_flag_q <= 1'b0;
            end else begin
                case (st_q)
                    PFPS_POSN: begin
                        if (at_tgt && press_in_position_flag_q) begin
                            st_q         <= PFPS_PRESS;
                            tgt_q        <= press_end_q;
                            press_in_position_flag_q <= 1'b0;
                            acc_clr_q    <= 1'b1;
                        end else if (at_tgt) begin
                            st_q <= PFPS_IDLE;
                        end
                    end
                    PFPS_PRESS: begin
                        if (acc_done) begin
                            st_q         <= PFPS_IDLE;
                            tgt_q        <= act_pos_i;
                            from_press_q <= 1'b1;
                        end else if (at_tgt) begin
                            st_q         <= PFPS_IDLE;
                            miss_q       <= 1'b1;
                            from_press_q <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Rated current during the approach, set percent while pressing
    wire [`PFPS_PCT_W-1:0] lim_d =
        (start_rise || discard) ? `PFPS_RATED_PCT :
        (st_q == PFPS_POSN && at_tgt && press_in_position_flag_q) ? pct_q :
        cur_limit_o;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_position_flag_q       <= 1'b0;
            move_q       <= 1'b0;
            cur_limit_o  <= `PFPS_RATED_PCT;
            servo_hold_o <= 1'b0;
            completed_position_bits_o <= '0;
        end else begin
            in_position_flag_q       <= in_position_flag_d;
            move_q       <= move_d;
            cur_limit_o  <= lim_d;
            servo_hold_o <= pio.pause;
            completed_position_bits_o <=
                (in_position_flag_d && !move_d) ? cur_sel_q : '0;
        end
    end

    assign target_pos_o       = tgt_q;
    assign in_position_flag_o = in_position_flag_q;
    assign motion_active_o    = move_q;

    // ----------------------------------------------------------------
    // Register read-back
    // ----------------------------------------------------------------
    wire [`PFPS_DATA_W-1:0] status_w = {
        27'h0, pio.pause, miss_q, in_press, in_position_flag_q, move_q};
    wire [`PFPS_DATA_W-1:0] rd_mux =
        (reg_addr_i == `PFPS_REG_SOFTLIM) ? softlim_q :
        (reg_addr_i == `PFPS_REG_TAB_IDX) ? `PFPS_DATA_W'(tab_idx_q) :
        (reg_addr_i == `PFPS_REG_TAB_POS) ? tab_pos_q :
        (reg_addr_i == `PFPS_REG_TAB_WID) ? tab_wid_q :
        (reg_addr_i == `PFPS_REG_STATUS)  ? status_w :
        (reg_addr_i == `PFPS_REG_TARGET)  ? tgt_q :
        (reg_addr_i == `PFPS_REG_ACC)     ? `PFPS_DATA_W'(acc_val) :
        '0;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= reg_re_i ? rd_mux : '0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_start_flags: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        start_rise |=> motion_active_o && !in_position_flag_o)
        else $error("start did not raise motion and drop in_position_flag");
    a_moving_zero_no: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        motion_active_o |-> completed_position_bits_o == '0)
        else $error("completed number nonzero while moving");
    a_pitch_target: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (start_rise && ent.inc && !over_lim && !under_lim)
        |=> tgt_q == $past(pitch_base) + $past(ent.pos))
        else $error("pitch target is not base plus pitch");
    a_pitch_limit: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (start_rise && ent.inc && over_lim) |=> tgt_q == softlim_q)
        else $error("pitch target passed the stroke limit");
    a_press_done_in_position_flag: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (in_press && acc_done && !start_rise && !discard)
        |=> in_position_flag_o && !motion_active_o)
        else $error("pressing limit time did not set in_position_flag");
    a_press_miss: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (in_press && at_tgt && !acc_done && !start_rise && !discard)
        |=> !in_position_flag_o && miss_q && st_q == PFPS_IDLE)
        else $error("miss-press left in_position_flag set");
    a_pause_discard: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (discard && !start_rise)
        |=> tgt_q == $past(act_pos_i) && !motion_active_o)
        else $error("alarm clear in pause kept the distance");
    a_press_abort: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (in_press && start_rise && ent.inc && ent.pct == '0)
        |=> st_q == PFPS_POSN && cur_limit_o == `PFPS_RATED_PCT)
        else $error("pitch start did not abort pressing");
endmodule : pfps_seq

// File: hw/pfps_defines.svh
// Constants for the pitch-feed and pressing sequencer
`ifndef PFPS_DEFINES_SVH
`define PFPS_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PFPS_POS_W        32
`define PFPS_SEL_W        9
`define PFPS_PCT_W        8
`define PFPS_ADDR_W       8
`define PFPS_DATA_W       32
`define PFPS_ACC_W        8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PFPS_CLK_PS       8000
`define PFPS_TICK_MS      1
`define PFPS_TICK_CYC     ((`PFPS_TICK_MS * 1000000000) / `PFPS_CLK_PS)
`define PFPS_PRESS_MS     255
`define PFPS_PRESS_TICKS  (`PFPS_PRESS_MS / `PFPS_TICK_MS)

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PFPS_REG_SOFTLIM  8'h00
`define PFPS_REG_TAB_IDX  8'h04
`define PFPS_REG_TAB_POS  8'h08
`define PFPS_REG_TAB_WID  8'h0C
`define PFPS_REG_TAB_CFG  8'h10
`define PFPS_REG_STATUS   8'h14
`define PFPS_REG_TARGET   8'h18
`define PFPS_REG_ACC      8'h1C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PFPS_CFG_INC_BIT  8
`define PFPS_ST_MOVE_BIT  0
`define PFPS_ST_IN_POSITION_FLAG_BIT  1
`define PFPS_ST_PRESS_BIT 2
`define PFPS_ST_MISS_BIT  3
`define PFPS_ST_PAUSE_BIT 4
`define PFPS_SOFTLIM_RST  32'h0001_0000
`define PFPS_RATED_PCT    8'h64

`endif

// File: hw/pfps_pkg.sv
// Types shared by the pitch-feed and pressing sequencer
`include "pfps_defines.svh"

package pfps_pkg;

    typedef enum logic [1:0] {
        PFPS_IDLE,
        PFPS_POSN,
        PFPS_PRESS
    } pfps_state_t;

    typedef struct packed {
        logic                   pause;
        logic                   clear;
        logic                   start;
        logic [`PFPS_SEL_W-1:0] sel;
    } pfps_pio_t;

    typedef struct packed {
        logic                          inc;
        logic [`PFPS_PCT_W-1:0]        pct;
        logic signed [`PFPS_POS_W-1:0] pos;
        logic signed [`PFPS_POS_W-1:0] wid;
    } pfps_entry_t;

endpackage : pfps_pkg

// File: hw/pfps_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
module pfps_pin_sync #(
    parameter int W = 12
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                q_o[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                q_o[i] <= s3_q[i];
            end
        end
    end
endmodule : pfps_pin_sync

// File: hw/pfps_press_acc.sv
// Pressing-completion time accumulator
`include "pfps_defines.svh"
module pfps_press_acc
    import pfps_pkg::*;
#(
    parameter int LIMIT = `PFPS_PRESS_TICKS
) (
    input  wire logic                   sys_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   clr_i,
    input  wire logic                   tick_i,
    input  wire logic                   over_i,
    output logic                        done_o,
    output logic [`PFPS_ACC_W-1:0]      acc_o
);
    localparam logic [`PFPS_ACC_W-1:0] LIM = `PFPS_ACC_W'(LIMIT);
    localparam logic [`PFPS_ACC_W-1:0] TOP = '1;

    logic [`PFPS_ACC_W-1:0] acc_d;
    wire  at_floor = (acc_o == '0);
    wire  at_top   = (acc_o == TOP);

    // Up while current at limit, down below it, never under zero
    assign acc_d = clr_i ? '0 :
                   !tick_i ? acc_o :
                   over_i ? (at_top ? acc_o : acc_o + 1'b1) :
                   (at_floor ? acc_o : acc_o - 1'b1);

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_o  <= '0;
            done_o <= 1'b0;
        end else begin
            acc_o  <= acc_d;
            done_o <= !clr_i && (acc_d >= LIM);
        end
    end

    a_acc_floor_hold: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (tick_i && !over_i && !clr_i && acc_o == '0) |=> acc_o == '0)
        else $error("accumulator went below zero");
    a_acc_clear_zero: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        clr_i |=> (acc_o == '0) && !done_o)
        else $error("accumulator not cleared");
    a_acc_done_level: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (tick_i && over_i && !clr_i && acc_o == LIM - 1'b1)
        |=> done_o && acc_o == LIM)
        else $error("done missing at the time limit");
endmodule : pfps_press_acc

// File: test/pfps_plc_model.sv
// Host model driving position number and start strobe
module pfps_plc_model #(
    parameter int HOLD = 8
) (
    input  wire logic       clk_i,
    input  wire logic       in_position_flag_i,
    output logic      [8:0] sel_o,
    output logic            strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sel_o = '0;
        strobe_o = 1'b0;
    end
    // Settle time scaled down so the run stays short
    task automatic go(input logic [8:0] n);
        sel_o <= n;
        repeat (HOLD) @(posedge clk_i);
        strobe_o <= 1'b1;
    endtask : go
    // Release on in-position, not on the motion flag
    task automatic done(input int lim);
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < lim && in_position_flag_i !== 1'b1; i++) @(posedge clk_i);
        strobe_o <= 1'b0;
        @(posedge clk_i);
    endtask : done
endmodule : pfps_plc_model

// File: test/tb.sv
// Self-checking bench for the pitch-feed and pressing sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               sys_clk_i = 1'b0;
    logic               rst_n_i = 1'b0;
    logic        [7:0]  addr = '0;
    logic        [31:0] wdata = '0;
    logic        [31:0] rdata;
    logic               we = 1'b0;
    logic               re = 1'b0;
    logic               re_d = 1'b0;
    logic               in_position_flag, move, strobe, hold;
    logic               pause = 1'b0;
    logic               aclr = 1'b0;
    logic        [8:0]  sel, done_no;
    logic        [7:0]  cur = 8'h40;
    logic        [7:0]  lim;
    logic signed [31:0] target;
    logic signed [31:0] act = '0;
    logic signed [31:0] wall = 32'sh7FFF_FFFF;
    logic        [31:0] q[$];
    int                 mismatches = 0;
    int                 tests_run = 0;
    int                 cyc = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    pfps_seq #(.TICK_CYC(4)) uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .position_start_strobe_i(strobe),
        .position_select_bits_i(sel), .alarm_clear_input_i(aclr),
        .pause_i(pause), .act_pos_i(act), .motor_cur_pct_i(cur),
        .target_pos_o(target), .cur_limit_o(lim), .servo_hold_o(hold),
        .in_position_flag_o(in_position_flag), .motion_active_o(move),
        .completed_position_bits_o(done_no));
    pfps_plc_model plc (.clk_i(sys_clk_i), .in_position_flag_i(in_position_flag), .sel_o(sel),
        .strobe_o(strobe));
    // Shaft freezes on hold; the workpiece stops it only at reduced current
    always @(posedge sys_clk_i) begin
        cur <= 8'h40 + 8'($urandom % 16);
        if (hold) act <= act;
        else if (act < target && (act < wall || lim == 8'h64)) act <= act + 1;
        else if (act > target) act <= act - 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    always @(posedge sys_clk_i) begin
        if (re_d) chk(rdata, q.pop_front());
        re_d <= re;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge sys_clk_i);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_i);
        addr <= a;
        re <= 1'b1;
        q.push_back(e);
        @(posedge sys_clk_i);
        re <= 1'b0;
    endtask : rd
    task automatic entry(input logic [8:0] n, input logic [31:0] p, w, c);
        wr(8'h04, 32'(n));
        wr(8'h08, p);
        wr(8'h0C, w);
        wr(8'h10, c);
    endtask : entry
    task automatic run(input logic [8:0] n, input logic [31:0] t, cn);
        plc.go(n);
        repeat (8) @(posedge sys_clk_i);
        chk(32'(move), 32'h1);
        chk(32'(done_no), 32'h0);
        plc.done(3000);
        repeat (4) @(posedge sys_clk_i);
        chk(32'(done_no), cn);
        rd(8'h18, t);
    endtask : run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    initial begin
        void'($urandom(32'h63c76150));
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        entry(9'h001, 32'h64, 32'h2, 32'h0);
        entry(9'h002, 32'h19, 32'h2, 32'h100);
        entry(9'h003, 32'h32, 32'h14, 32'h32);
        rd(8'h00, 32'h0001_0000);
        rd(8'h40, 32'h0);
        $display("test registers done");
        run(9'h001, 32'h64, 32'h1);
        run(9'h002, 32'h7D, 32'h2);
        run(9'h002, 32'h96, 32'h2);
        wr(8'h00, 32'hA0);
        run(9'h002, 32'hA0, 32'h2);
        chk(32'(in_position_flag), 32'h1);
        $display("test pitch done");
        run(9'h003, 32'h46, 32'h0);
        chk(32'(in_position_flag), 32'h0);
        rd(8'h14, 32'h8);
        wall <= 32'sh37;
        plc.go(9'h003);
        repeat (100) @(posedge sys_clk_i);
        chk(32'(lim), 32'h32);
        plc.done(3000);
        chk(32'(in_position_flag), 32'h1);
        run(9'h002, 32'h4B, 32'h2);
        $display("test pressing done");
        pause <= 1'b1;
        plc.go(9'h002);
        plc.done(0);
        chk(32'(hold), 32'h1);
        plc.go(9'h002);
        plc.done(0);
        rd(8'h18, 32'h7D);
        aclr <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        chk(32'(move), 32'h0);
        rd(8'h18, 32'h4B);
        aclr <= 1'b0;
        pause <= 1'b0;
        run(9'h002, 32'h64, 32'h2);
        plc.go(9'h003);
        repeat (150) @(posedge sys_clk_i);
        chk(32'(lim), 32'h32);
        plc.done(0);
        run(9'h002, 32'h4B, 32'h2);
        chk(32'(lim), 32'h64);
        repeat (2) @(posedge sys_clk_i);
        $display("test pause and abort done");
        finish_test();
    end
endmodule : tb
